// ---- core/iox_apb_regs.sv ----
// APB register file with sticky event status, mask and interrupt
`timescale 1ns/1ps
`include "iox_params.svh"
module iox_apb_regs
   import iox_pkg::*;
(
   input logic clk,
   input logic rst,
   input iox_apb_req_t req,
   output iox_apb_rsp_t rsp,
   input iox_evt_t ev,
   input logic [7:0] info,
   output logic [1:0] ctrl,
   output logic irq
);
   iox_regs_t s;
   iox_regs_t n;
   logic wr;
   logic [5:0] clr;

   always_comb begin
      n = s;
      clr = 6'h00;
      n.rsp.pready = 1'b0;
      n.rsp.pslverr = 1'b0;
      n.rsp.prdata = 32'h0;
      // Answer is prepared in setup so the access phase never waits
      if (req.psel && !req.penable) begin
         n.rsp.pready = 1'b1;
         if (req.paddr == `IOX_OFS_CTRL) begin
            n.rsp.prdata = {30'h0, s.ctrl};
         end else if (req.paddr == `IOX_OFS_STATUS) begin
            n.rsp.prdata = {26'h0, s.sts};
         end else if (req.paddr == `IOX_OFS_MASK) begin
            n.rsp.prdata = {26'h0, s.msk};
         end else if (req.paddr == `IOX_OFS_STATE) begin
            n.rsp.prdata = {24'h0, info};
         end else begin
            n.rsp.pslverr = 1'b1;
         end
      end
      wr = req.psel && req.penable && s.rsp.pready && req.pwrite && !s.rsp.pslverr;
      if (wr) begin
         if (req.paddr == `IOX_OFS_CTRL) begin
            n.ctrl = req.pwdata[1:0];
         end else if (req.paddr == `IOX_OFS_STATUS) begin
            clr = req.pwdata[5:0];
         end else if (req.paddr == `IOX_OFS_MASK) begin
            n.msk = req.pwdata[5:0];
         end
      end
      // A new event beats a clear written in the same cycle
      n.sts = (s.sts & ~clr) | ev;
      n.irq = |(n.sts & n.msk);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.ctrl <= `IOX_CTRL_RESET;
         s.msk <= `IOX_MASK_RESET;
      end else begin
         s <= n;
      end
   end

   assign rsp = s.rsp;
   assign ctrl = s.ctrl;
   assign irq = s.irq;
endmodule : iox_apb_regs

// ---- core/iox_out_exec.sv ----
// Execution unit for the port output and string port output instructions
`timescale 1ns/1ps
`include "iox_params.svh"
module iox_out_exec
   import iox_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic issue,
   input iox_instr_t instr,
   input iox_mode_t mode,
   input logic [31:0] accum,
   input logic [15:0] port_reg,
   input logic [31:0] src_idx_in,
   input logic [31:0] count_in,
   input logic perm_valid,
   input logic [3:0] perm_bits,
   output logic perm_req,
   output logic [15:0] perm_port,
   output logic [2:0] perm_len,
   output logic mem_req,
   output logic [31:0] mem_addr,
   output logic [2:0] mem_len,
   input iox_mem_rsp_t mem_rsp,
   output iox_io_wr_t io_wr,
   output logic busy,
   output logic done,
   output iox_fault_t fault,
   output logic [31:0] src_idx_out,
   output logic [31:0] count_out,
   input iox_apb_req_t apb_req,
   output iox_apb_rsp_t apb_rsp,
   output logic irq
);
   iox_core_t s;
   iox_core_t n;
   logic [1:0] ctrl;
   logic str;
   logic accept;
   logic real_ovf;
   logic misaligned;
   logic [31:0] sa;
   iox_fault_t fk;
   logic [31:0] stp;

   function automatic logic f_is_str(input logic [7:0] op);
      return op == `IOX_OP_STR_B || op == `IOX_OP_STR_V;
   endfunction : f_is_str

   function automatic logic f_is_imm(input logic [7:0] op);
      return op == `IOX_OP_OUT_IMM_B || op == `IOX_OP_OUT_IMM_V;
   endfunction : f_is_imm

   function automatic logic f_valid(input logic [7:0] op);
      return f_is_str(op) || f_is_imm(op) || op == `IOX_OP_OUT_REG_B
         || op == `IOX_OP_OUT_REG_V;
   endfunction : f_valid

   // Even opcode is the byte form; the odd one follows the operand size
   function automatic logic [2:0] f_width(input iox_instr_t i);
      if (!i.opcode[0]) begin
         return 3'd1;
      end
      return i.osz32 ? 3'd4 : 3'd2;
   endfunction : f_width

   function automatic logic [3:0] f_lanes(input logic [2:0] w);
      if (w == 3'd1) begin
         return 4'h1;
      end else if (w == 3'd2) begin
         return 4'h3;
      end
      return 4'hf;
   endfunction : f_lanes

   function automatic logic [31:0] f_data(input logic [31:0] d, input logic [2:0] w);
      if (w == 3'd1) begin
         return {24'h0, d[7:0]};
      end else if (w == 3'd2) begin
         return {16'h0, d[15:0]};
      end
      return d;
   endfunction : f_data

   function automatic logic [31:0] f_step(input logic [2:0] w, input logic df);
      return df ? 32'h0 - {29'h0, w} : {29'h0, w};
   endfunction : f_step

   function automatic logic f_need_perm(input iox_mode_t m);
      return m.pe && (m.vm || m.current_privilege_level > m.io_privilege_level);
   endfunction : f_need_perm

   function automatic logic [5:0] f_clocks(input iox_instr_t i, input iox_mode_t m);
      logic [1:0] k;
      logic [5:0] c;
      if (!m.pe) begin
         k = 2'd0;
      end else if (m.vm) begin
         k = 2'd1;
      end else if (m.current_privilege_level <= m.io_privilege_level) begin
         k = 2'd2;
      end else begin
         k = 2'd3;
      end
      if (f_is_str(i.opcode)) begin
         case (k)
            2'd0: c = `IOX_CK_STR_REAL;
            2'd1: c = `IOX_CK_STR_V86;
            2'd2: c = `IOX_CK_STR_PM_OK;
            default: c = `IOX_CK_STR_PM_IO;
         endcase
      end else if (f_is_imm(i.opcode)) begin
         case (k)
            2'd0: c = `IOX_CK_IMM_REAL;
            2'd1: c = `IOX_CK_IMM_V86;
            2'd2: c = `IOX_CK_IMM_PM_OK;
            default: c = `IOX_CK_IMM_PM_IO;
         endcase
      end else begin
         case (k)
            2'd0: c = `IOX_CK_REG_REAL;
            2'd1: c = `IOX_CK_REG_V86;
            2'd2: c = `IOX_CK_REG_PM_OK;
            default: c = `IOX_CK_REG_PM_IO;
         endcase
      end
      return c;
   endfunction : f_clocks

   iox_apb_regs u_regs (
      .clk(clk),
      .rst(rst),
      .req(apb_req),
      .rsp(apb_rsp),
      .ev(s.ev),
      .info({4'h0, s.busy, s.st}),
      .ctrl(ctrl),
      .irq(irq)
   );

   assign str = f_is_str(s.ins.opcode);
   // Sized synonyms share the two string opcodes, so one decode serves all
   assign accept = (s.st == IOX_IDLE) && issue && ctrl[`IOX_CTRL_EN_BIT]
      && f_valid(instr.opcode);
   assign sa = s.ins.asz32 ? s.idx : {16'h0, s.idx[15:0]};
   assign real_ovf = ({1'b0, s.idx[15:0]} + {14'h0, s.wid} - 17'h1) > `IOX_REAL_LIMIT;
   assign misaligned = |(sa[1:0] & (s.wid[1:0] - 2'd1));
   assign stp = f_step(s.wid, s.md.df);

   always_comb begin
      n = s;
      fk = IOX_F_NONE;
      n.io.valid = 1'b0;
      n.done = 1'b0;
      n.fault = IOX_F_NONE;
      n.ev = '0;
      if (s.busy && s.cyc != 6'h3f) begin
         n.cyc = s.cyc + 6'd1;
      end
      case (s.st)
         IOX_IDLE: begin
            if (accept) begin
               n.ins = instr;
               n.md = mode;
               n.acc = accum;
               n.port = f_is_imm(instr.opcode) ? {8'h00, instr.imm8} : port_reg;
               n.idx = src_idx_in;
               n.cnt = count_in;
               n.wid = f_width(instr);
               n.tgt = f_clocks(instr, mode);
               n.cyc = 6'd1;
               n.busy = 1'b1;
               if (f_is_str(instr.opcode) && instr.iteration_prefix && count_in == 32'h0) begin
                  n.busy = 1'b0;
                  n.done = 1'b1;
                  n.ev.done = 1'b1;
               end else if (f_need_perm(mode)) begin
                  n.st = IOX_PERM;
                  n.perm_req = 1'b1;
               end else if (f_is_str(instr.opcode)) begin
                  n.st = IOX_FETCH;
               end else begin
                  n.st = IOX_OUT;
               end
            end
         end
         IOX_PERM: begin
            if (perm_valid) begin
               n.perm_req = 1'b0;
               if (|(perm_bits & f_lanes(s.wid))) begin
                  fk = IOX_F_GP;
               end else begin
                  n.st = str ? IOX_FETCH : IOX_OUT;
               end
            end
         end
         IOX_FETCH: begin
            if (!s.mem_req) begin
               if ((!s.md.pe || s.md.vm) && !s.ins.asz32 && real_ovf) begin
                  fk = IOX_F_INT13;
               end else if (s.md.pe && s.md.current_privilege_level == `IOX_CPL_ALIGN && misaligned
                  && ctrl[`IOX_CTRL_AC_BIT]) begin
                  fk = IOX_F_AC;
               end else begin
                  n.mem_req = 1'b1;
                  n.madr = sa;
               end
            end else if (mem_rsp.valid) begin
               n.mem_req = 1'b0;
               if (mem_rsp.page_err) begin
                  fk = IOX_F_PF;
               end else if (mem_rsp.limit_err) begin
                  if (!s.md.pe || s.md.vm) begin
                     fk = IOX_F_INT13;
                  end else begin
                     fk = mem_rsp.stack_seg ? IOX_F_SS : IOX_F_GP;
                  end
               end else begin
                  n.dat = mem_rsp.data;
                  n.st = IOX_OUT;
               end
            end
         end
         IOX_OUT: begin
            // One write per element; the flag state is never touched here
            n.io.valid = 1'b1;
            n.io.port = s.port;
            n.io.data = f_data(str ? s.dat : s.acc, s.wid);
            n.io.be = f_lanes(s.wid);
            if (str) begin
               if (s.ins.asz32) begin
                  n.idx = s.idx + stp;
               end else begin
                  n.idx[15:0] = s.idx[15:0] + stp[15:0];
               end
            end
            n.st = IOX_HOLD;
         end
         IOX_HOLD: begin
            // Pad each element out to its fixed clock count
            if (s.cyc >= s.tgt - 6'd1) begin
               if (str && s.ins.iteration_prefix && s.cnt != 32'h1) begin
                  n.cnt = s.cnt - 32'h1;
                  n.cyc = 6'd0;
                  n.perm_req = f_need_perm(s.md);
                  n.st = f_need_perm(s.md) ? IOX_PERM : IOX_FETCH;
               end else begin
                  if (str && s.ins.iteration_prefix) begin
                     n.cnt = s.cnt - 32'h1;
                  end
                  n.done = 1'b1;
                  n.ev.done = 1'b1;
                  n.busy = 1'b0;
                  n.st = IOX_IDLE;
               end
            end
         end
         default: begin
            n.st = IOX_IDLE;
         end
      endcase
      // A fault leaves index and count at the last completed element
      if (fk != IOX_F_NONE) begin
         n.fault = fk;
         n.busy = 1'b0;
         n.perm_req = 1'b0;
         n.mem_req = 1'b0;
         n.st = IOX_IDLE;
         n.ev.gp = (fk == IOX_F_GP);
         n.ev.ss = (fk == IOX_F_SS);
         n.ev.pf = (fk == IOX_F_PF);
         n.ev.ac = (fk == IOX_F_AC);
         n.ev.int13 = (fk == IOX_F_INT13);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign perm_req = s.perm_req;
   assign perm_port = s.port;
   assign perm_len = s.wid;
   assign mem_req = s.mem_req;
   assign mem_addr = s.madr;
   assign mem_len = s.wid;
   assign io_wr = s.io;
   assign busy = s.busy;
   assign done = s.done;
   assign fault = s.fault;
   assign src_idx_out = s.idx;
   assign count_out = s.cnt;

   // Cycle count since the instruction was taken, read only by the checks
   logic [7:0] el_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         el_r <= 8'h0;
      end else if (accept) begin
         el_r <= 8'h1;
      end else if (s.busy) begin
         el_r <= el_r + 8'h1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence seq_deny;
      s.st == IOX_PERM && perm_valid && |(perm_bits & f_lanes(s.wid));
   endsequence
   sequence seq_abort;
      s.fault == IOX_F_GP && !s.busy && !s.io.valid;
   endsequence

   chk_imm_port_ext: assert property (
      s.io.valid && f_is_imm(s.ins.opcode) |-> s.io.port[15:8] == 8'h00)
      else $error("immediate port not zero-extended");
   chk_real_no_perm: assert property (
      s.perm_req |-> s.md.pe && (s.md.vm || s.md.current_privilege_level > s.md.io_privilege_level))
      else $error("permission check outside protected low privilege");
   chk_perm_deny: assert property (seq_deny |=> seq_abort ##1 !s.io.valid)
      else $error("denied port was not aborted");
   chk_out_once: assert property (s.io.valid |=> !s.io.valid)
      else $error("more than one write per element");
   chk_exact_clk: assert property (
      s.done && !s.md.pe && !str |-> el_r == {2'h0, s.tgt})
      else $error("port write clock count wrong");
   chk_min_clk: assert property (s.done && !s.ins.iteration_prefix |-> el_r >= {2'h0, s.tgt})
      else $error("instruction finished early");
   chk_reg_clk: assert property (
      accept && instr.opcode == `IOX_OP_OUT_REG_B && mode.pe && !mode.vm
      && mode.current_privilege_level <= mode.io_privilege_level |=> s.tgt == 6'd10)
      else $error("register form clock target wrong");
   chk_str_step: assert property (
      s.io.valid && str && s.ins.asz32 |->
      s.idx == $past(s.idx) + f_step(s.wid, s.md.df))
      else $error("source index stepped wrongly");
   chk_idx16_high: assert property (
      s.io.valid && str && !s.ins.asz32 |-> s.idx[31:16] == $past(s.idx[31:16]))
      else $error("16-bit index touched upper half");
   chk_byte_step: assert property (
      s.io.valid && str && s.wid == 3'd1 && !s.md.df |-> s.idx[1:0] == $past(s.idx[1:0]) + 2'd1)
      else $error("byte step is not one");
   chk_rep_drain: assert property (s.done && str && s.ins.iteration_prefix |-> s.cnt == 32'h0)
      else $error("block output left count nonzero");
   chk_int13_mode: assert property (s.fault == IOX_F_INT13 |-> !s.md.pe || s.md.vm)
      else $error("interrupt 13 raised in protected mode");
   chk_byte_data: assert property (
      s.io.valid && s.wid == 3'd1 |-> s.io.data[31:8] == 24'h0 && s.io.be == 4'h1)
      else $error("byte write carries extra lanes");
   chk_pf_report: assert property (
      s.st == IOX_FETCH && s.mem_req && mem_rsp.valid && mem_rsp.page_err
      |=> s.fault == IOX_F_PF)
      else $error("page fault not reported");
endmodule : iox_out_exec

// ---- inc/iox_params.svh ----
// Offsets, field positions, reset values and clock counts of the port output unit
`ifndef IOX_PARAMS_SVH
`define IOX_PARAMS_SVH
`define IOX_OP_OUT_IMM_B 8'he6
`define IOX_OP_OUT_IMM_V 8'he7
`define IOX_OP_OUT_REG_B 8'hee
`define IOX_OP_OUT_REG_V 8'hef
`define IOX_OP_STR_B 8'h6e
`define IOX_OP_STR_V 8'h6f
`define IOX_CK_IMM_REAL 6'd16
`define IOX_CK_IMM_V86 6'd29
`define IOX_CK_IMM_PM_OK 6'd11
`define IOX_CK_IMM_PM_IO 6'd31
`define IOX_CK_REG_REAL 6'd16
`define IOX_CK_REG_V86 6'd29
`define IOX_CK_REG_PM_OK 6'd10
`define IOX_CK_REG_PM_IO 6'd30
`define IOX_CK_STR_REAL 6'd17
`define IOX_CK_STR_V86 6'd30
`define IOX_CK_STR_PM_OK 6'd10
`define IOX_CK_STR_PM_IO 6'd32
`define IOX_REAL_LIMIT 17'h0ffff
`define IOX_CPL_ALIGN 2'h3
`define IOX_OFS_CTRL 32'h0000_0000
`define IOX_OFS_STATUS 32'h0000_0004
`define IOX_OFS_MASK 32'h0000_0008
`define IOX_OFS_STATE 32'h0000_000c
`define IOX_CTRL_EN_BIT 0
`define IOX_CTRL_AC_BIT 1
`define IOX_CTRL_RESET 2'h1
`define IOX_MASK_RESET 6'h00
`endif

// ---- inc/iox_pkg.sv ----
// Types of the port output unit
package iox_pkg;
   typedef enum logic [2:0] {IOX_IDLE, IOX_PERM, IOX_FETCH, IOX_OUT, IOX_HOLD} iox_state_t;
   typedef enum logic [2:0] {
      IOX_F_NONE, IOX_F_GP, IOX_F_SS, IOX_F_PF, IOX_F_AC, IOX_F_INT13
   } iox_fault_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] imm8;
      logic iteration_prefix;
      logic asz32;
      logic osz32;
   } iox_instr_t;
   typedef struct packed {
      logic pe;
      logic vm;
      logic [1:0] current_privilege_level;
      logic [1:0] io_privilege_level;
      logic df;
   } iox_mode_t;
   typedef struct packed {
      logic valid;
      logic [31:0] data;
      logic limit_err;
      logic stack_seg;
      logic page_err;
   } iox_mem_rsp_t;
   typedef struct packed {
      logic valid;
      logic [15:0] port;
      logic [31:0] data;
      logic [3:0] be;
   } iox_io_wr_t;
   typedef struct packed {
      logic int13;
      logic ac;
      logic pf;
      logic ss;
      logic gp;
      logic done;
   } iox_evt_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } iox_apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } iox_apb_rsp_t;
   typedef struct packed {
      iox_state_t st;
      iox_instr_t ins;
      iox_mode_t md;
      logic [31:0] acc;
      logic [15:0] port;
      logic [31:0] idx;
      logic [31:0] cnt;
      logic [31:0] dat;
      logic [31:0] madr;
      logic [2:0] wid;
      logic [5:0] cyc;
      logic [5:0] tgt;
      logic perm_req;
      logic mem_req;
      iox_io_wr_t io;
      logic busy;
      logic done;
      iox_fault_t fault;
      iox_evt_t ev;
   } iox_core_t;
   typedef struct packed {
      logic [1:0] ctrl;
      logic [5:0] sts;
      logic [5:0] msk;
      iox_apb_rsp_t rsp;
      logic irq;
   } iox_regs_t;
endpackage : iox_pkg

// ---- sim/io_port_output_exec_tb_top.sv ----
// Testbench for the port output execution unit
`timescale 1ns/1ps
`include "iox_params.svh"
module io_port_output_exec_tb_top;
   import iox_pkg::*;
   logic clk, rst, issue, perm_valid, perm_req, mem_req, busy, done, irq, er;
   logic [3:0] perm_bits, deny;
   logic [2:0] errs;
   logic [7:0] lat;
   logic [15:0] port_reg, perm_port;
   logic [31:0] accum, src_idx_in, count_in, mem_addr, src_idx_out, count_out, rd;
   iox_instr_t instr;
   iox_mode_t mode;
   iox_mem_rsp_t mem_rsp;
   iox_io_wr_t io_wr, lw;
   iox_fault_t fault, f;
   iox_apb_req_t apb_req;
   iox_apb_rsp_t apb_rsp;
   int cmp_count, miscompares, nwr, n, i;
   localparam iox_mode_t m_real = 7'h00;
   localparam iox_mode_t m_v86 = 7'h78;
   localparam iox_mode_t m_ok = 7'h46;
   localparam iox_mode_t m_io = 7'h58;
   logic [7:0] ops [3] = '{8'he6, 8'hee, 8'h6e};
   logic [5:0] tt [12] = '{`IOX_CK_IMM_REAL, `IOX_CK_IMM_V86, `IOX_CK_IMM_PM_OK,
      `IOX_CK_IMM_PM_IO, `IOX_CK_REG_REAL, `IOX_CK_REG_V86, `IOX_CK_REG_PM_OK,
      `IOX_CK_REG_PM_IO, `IOX_CK_STR_REAL, `IOX_CK_STR_V86, `IOX_CK_STR_PM_OK,
      `IOX_CK_STR_PM_IO};
   iox_mode_t mds [4] = '{m_real, m_v86, m_ok, m_io};
   iox_out_exec iox_out_exec_inst (.clk(clk), .rst(rst), .issue(issue), .instr(instr),
      .mode(mode), .accum(accum), .port_reg(port_reg), .src_idx_in(src_idx_in),
      .count_in(count_in), .perm_valid(perm_valid), .perm_bits(perm_bits),
      .perm_req(perm_req), .perm_port(perm_port), .perm_len(), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_len(), .mem_rsp(mem_rsp), .io_wr(io_wr), .busy(busy),
      .done(done), .fault(fault), .src_idx_out(src_idx_out), .count_out(count_out),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .irq(irq));
   iox_peer_model iox_peer_model_inst (.clk(clk), .perm_req(perm_req), .mem_req(mem_req),
      .mem_addr(mem_addr), .deny(deny), .errs(errs), .lat(lat), .perm_valid(perm_valid),
      .perm_bits(perm_bits), .mem_rsp(mem_rsp));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (io_wr.valid === 1'b1) begin
         nwr++;
         lw <= io_wr;
      end
   end
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (apb_rsp.pready === 1'b1) break;
      end
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req <= '0;
      if (k == 50) begin
         miscompares++;
         close_out();
      end
   endtask : apb
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", e, rd);
   endtask : rchk
   // Issue edge is cycle 0; n counts cycles up to done or fault
   task automatic go(input iox_instr_t ins, input iox_mode_t md);
      @(posedge clk);
      issue <= 1'b1;
      instr <= ins;
      mode <= md;
      @(posedge clk);
      issue <= 1'b0;
      for (n = 1; n < 3000; n++) begin
         @(negedge clk);
         if (done === 1'b1 || fault !== IOX_F_NONE) break;
         @(posedge clk);
      end
      f = fault;
      if (n == 3000) begin
         miscompares++;
         close_out();
      end
   endtask : go
   task automatic fchk(input iox_instr_t ins, input iox_mode_t md, input logic [31:0] ix,
                       input logic [2:0] e, input logic [3:0] dn, input iox_fault_t x);
      int w;
      int ew;
      @(posedge clk);
      src_idx_in <= ix;
      errs <= e;
      deny <= dn;
      w = nwr;
      go(ins, md);
      // A prefixed string form writes once per element, others once
      ew = (ins.iteration_prefix && ins.opcode[7:1] == 7'h37) ? int'(count_in) : 1;
      chk("fault", x, f);
      chk("writes", w + ((x == IOX_F_NONE) ? ew : 0), nwr);
   endtask : fchk
   initial begin
      {rst, issue, instr, mode, deny, errs, lat, apb_req} = '0;
      rst = 1'b1;
      accum = 32'h1234_5678;
      port_reg = 16'hffff;
      src_idx_in = 32'h100;
      count_in = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rchk(`IOX_OFS_CTRL, 32'h1);
      rchk(`IOX_OFS_MASK, 32'h0);
      rchk(`IOX_OFS_STATUS, 32'h0);
      rchk(`IOX_OFS_STATE, 32'h0);
      apb(1'b0, 32'h10, 32'h0);
      chk("pslverr", 32'h1, er);
      for (i = 0; i < 12; i++) begin
         fchk({ops[i / 4], 8'h5a, 3'b000}, mds[i % 4], 32'h100, 3'h0, 4'h0, IOX_F_NONE);
         chk("clocks", tt[i], n);
      end
      go({8'he7, 8'ha5, 3'b001}, m_real);
      chk("port", 32'h00a5, lw.port);
      chk("data", 32'h1234_5678, lw.data);
      go({8'hef, 8'h00, 3'b000}, m_real);
      chk("port", 32'hffff, lw.port);
      chk("data", 32'h5678, lw.data);
      // Software sets index and count first; the peer stalls to stretch each element
      @(posedge clk);
      count_in <= 32'h3;
      lat <= 8'd20;
      fchk({8'h6e, 8'h00, 3'b100}, m_real, 32'h100, 3'h0, 4'h0, IOX_F_NONE);
      chk("count", 32'h0, count_out);
      chk("index", 32'h103, src_idx_out);
      chk("data", 32'h02, lw.data);
      chk("port", 32'hffff, lw.port);
      @(posedge clk);
      lat <= 8'd0;
      count_in <= 32'h2;
      fchk({8'h6f, 8'h00, 3'b101}, 7'h01, 32'h0001_0010, 3'h0, 4'h0, IOX_F_NONE);
      chk("index", 32'h0001_0008, src_idx_out);
      chk("data", 32'hfff3_000c, lw.data);
      fchk({8'h6e, 8'h00, 3'b110}, m_ok, 32'h0001_0100, 3'h0, 4'h0, IOX_F_NONE);
      chk("index", 32'h0001_0102, src_idx_out);
      @(posedge clk);
      count_in <= 32'h0;
      fchk({8'h6e, 8'h00, 3'b100}, m_real, 32'h100, 3'h0, 4'h0, IOX_F_NONE);
      chk("clocks", 32'h1, n);
      fchk({8'hee, 8'h00, 3'b000}, m_io, 32'h100, 3'h0, 4'h1, IOX_F_GP);
      chk("perm_port", 32'hffff, perm_port);
      fchk({8'he6, 8'h00, 3'b000}, m_v86, 32'h100, 3'h0, 4'h1, IOX_F_GP);
      fchk({8'hee, 8'h00, 3'b000}, m_ok, 32'h100, 3'h0, 4'hf, IOX_F_NONE);
      fchk({8'hee, 8'h00, 3'b000}, m_real, 32'h100, 3'h0, 4'hf, IOX_F_NONE);
      fchk({8'h6f, 8'h00, 3'b000}, m_real, 32'hffff, 3'h0, 4'h0, IOX_F_INT13);
      fchk({8'h6e, 8'h00, 3'b000}, m_ok, 32'h100, 3'h1, 4'h0, IOX_F_GP);
      fchk({8'h6e, 8'h00, 3'b000}, m_ok, 32'h100, 3'h3, 4'h0, IOX_F_SS);
      fchk({8'h6e, 8'h00, 3'b000}, m_ok, 32'h100, 3'h4, 4'h0, IOX_F_PF);
      apb(1'b1, `IOX_OFS_CTRL, 32'h3);
      fchk({8'h6f, 8'h00, 3'b011}, 7'h5e, 32'h101, 3'h0, 4'h0, IOX_F_AC);
      rchk(`IOX_OFS_STATUS, 32'h3f);
      chk("irq", 32'h0, irq);
      apb(1'b1, `IOX_OFS_MASK, 32'h2);
      rchk(`IOX_OFS_MASK, 32'h2);
      chk("irq", 32'h1, irq);
      apb(1'b1, `IOX_OFS_STATUS, 32'h3d);
      rchk(`IOX_OFS_STATUS, 32'h2);
      chk("irq", 32'h1, irq);
      apb(1'b1, `IOX_OFS_STATUS, 32'h2);
      rchk(`IOX_OFS_STATUS, 32'h0);
      chk("irq", 32'h0, irq);
      close_out();
   end
endmodule : io_port_output_exec_tb_top

// ---- sim/iox_peer_model.sv ----
// Peer model: I/O permission map, data segment memory, both answering after a set delay
`timescale 1ns/1ps
module iox_peer_model
   import iox_pkg::*;
(
   input logic clk,
   input logic perm_req,
   input logic mem_req,
   input logic [31:0] mem_addr,
   input logic [3:0] deny,
   input logic [2:0] errs,
   input logic [7:0] lat,
   output logic perm_valid,
   output logic [3:0] perm_bits,
   output iox_mem_rsp_t mem_rsp
);
   logic [7:0] pc_r;
   logic [7:0] mc_r;
   initial begin
      pc_r = 8'h00;
      mc_r = 8'h00;
      perm_valid = 1'b0;
      perm_bits = 4'h0;
      mem_rsp = '0;
   end
   // Outside a reply the permission bits and read data toggle, so nothing stale passes for data
   always @(posedge clk) begin
      perm_valid <= 1'b0;
      perm_bits <= ~perm_bits;
      pc_r <= (perm_req && !perm_valid) ? pc_r + 8'h01 : 8'h00;
      if (perm_req && !perm_valid && pc_r == lat) begin
         perm_valid <= 1'b1;
         perm_bits <= deny;
      end
      mem_rsp.valid <= 1'b0;
      mem_rsp.data <= ~mem_rsp.data;
      mc_r <= (mem_req && !mem_rsp.valid) ? mc_r + 8'h01 : 8'h00;
      if (mem_req && !mem_rsp.valid && mc_r == lat) begin
         mem_rsp <= '{1'b1, {~mem_addr[15:0], mem_addr[15:0]}, errs[0], errs[1], errs[2]};
      end
   end
endmodule : iox_peer_model
